// *** include/pif_pkg.sv ***
// package of constants for the peripheral interrupt flag register two block
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
package pif_pkg;
  localparam logic [11:0] PIF_FLAG_INDEX   = 12'h00D;
  localparam logic [11:0] PIF_FLAG_ADDR    = 12'h034;
  localparam logic [11:0] PIF_ENABLE_ADDR  = 12'h038;
  localparam logic [7:0]  PIF_FLAG_RESET   = 8'h00;
  localparam logic [7:0]  PIF_ENABLE_RESET = 8'h00;
  localparam logic [7:0]  PIF_IMPL_MASK    = 8'hF5;
  localparam int          PIF_OSC_BIT      = 7;
  localparam int          PIF_CMP2_BIT     = 6;
  localparam int          PIF_CMP1_BIT     = 5;
  localparam int          PIF_DISP_BIT     = 4;
  localparam int          PIF_LVD_BIT      = 2;
  localparam int          PIF_CCP2_BIT     = 0;
  localparam int          PIF_SYNC_STAGES  = 3;

  typedef struct packed {
    logic [7:0] flag_reg;
    logic [7:0] enable_reg;
    logic [7:0] sync1_reg;
    logic [7:0] sync2_reg;
    logic [7:0] sync3_reg;
    logic [7:0] prev_reg;
    logic [31:0] prdata_reg;
  } pif_state_type;
endpackage

// *** hdl/pif_flags.sv ***
// peripheral interrupt flag register two with apb slave
`timescale 1ns/1ps
`default_nettype none
module pif_flags (
  // ----------------------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------------------
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  // ----------------------------------------------------------------------------
  // event sources
  // ----------------------------------------------------------------------------
  input  wire logic        osc_fail_event,
  input  wire logic        cmp2_output,
  input  wire logic        cmp1_output,
  input  wire logic        display_module_event,
  input  wire logic        low_voltage_event,
  input  wire logic        capcomp2_event,
  // ----------------------------------------------------------------------------
  // processor side
  // ----------------------------------------------------------------------------
  output logic [7:0]       flag_out,
  output logic             irq
);
  import pif_pkg::*;

  // ----------------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------------
  pif_state_type state_reg;
  pif_state_type state_next;

  // synchroniser and edge detection
  logic [7:0]  raw_in;
  logic [7:0]  agree;
  logic [7:0]  level_now;
  logic [7:0]  rise;
  logic [7:0]  toggle;
  logic [7:0]  events;

  // register update
  logic [7:0]  clear_mask;
  logic [7:0]  flag_cleared;
  logic [7:0]  flag_set;
  logic [7:0]  enable_value;
  logic [7:0]  pending;

  // bus
  logic [7:0]  read_byte;
  logic [31:0] read_word;
  logic        setup_phase;
  logic        access_phase;
  logic        wr_en;
  logic        rd_en;
  logic        hit_flag;
  logic        hit_enable;
  logic        hit_any;

  // ----------------------------------------------------------------------------
  // source mapping
  // ----------------------------------------------------------------------------
  always_comb begin
    raw_in               = 8'h00;
    raw_in[PIF_OSC_BIT]  = osc_fail_event;
    raw_in[PIF_CMP2_BIT] = cmp2_output;
    raw_in[PIF_CMP1_BIT] = cmp1_output;
    raw_in[PIF_DISP_BIT] = display_module_event;
    raw_in[PIF_LVD_BIT]  = low_voltage_event;
    raw_in[PIF_CCP2_BIT] = capcomp2_event;
  end

  // ----------------------------------------------------------------------------
  // synchroniser agreement
  // ----------------------------------------------------------------------------
  always_comb begin
    // a change counts only once stages two and three agree
    agree     = ~(state_reg.sync2_reg ^ state_reg.sync3_reg);
    level_now = state_reg.prev_reg;
    for (int i = 0; i < 8; i++) begin
      if (agree[i]) begin
        level_now[i] = state_reg.sync3_reg[i];
      end else begin
        level_now[i] = state_reg.prev_reg[i];
      end
    end
  end

  // ----------------------------------------------------------------------------
  // event detection
  // ----------------------------------------------------------------------------
  always_comb begin
    rise                 = level_now & ~state_reg.prev_reg;
    toggle               = level_now ^ state_reg.prev_reg;
    events               = 8'h00;
    events[PIF_OSC_BIT]  = rise[PIF_OSC_BIT];
    events[PIF_CMP2_BIT] = toggle[PIF_CMP2_BIT];
    events[PIF_CMP1_BIT] = toggle[PIF_CMP1_BIT];
    events[PIF_DISP_BIT] = rise[PIF_DISP_BIT];
    events[PIF_LVD_BIT]  = rise[PIF_LVD_BIT];
    events[PIF_CCP2_BIT] = rise[PIF_CCP2_BIT];
  end

  // ----------------------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------------------
  assign setup_phase  = psel && !penable;
  assign access_phase = psel && penable;
  assign hit_flag     = (paddr == PIF_FLAG_ADDR);
  assign hit_enable   = (paddr == PIF_ENABLE_ADDR);
  assign hit_any      = hit_flag || hit_enable;
  assign wr_en        = access_phase && pwrite && pstrb[0];
  assign rd_en        = setup_phase && !pwrite;

  // ----------------------------------------------------------------------------
  // write path
  // ----------------------------------------------------------------------------
  always_comb begin
    clear_mask   = 8'h00;
    enable_value = state_reg.enable_reg;
    if (wr_en) begin
      case (paddr)
        PIF_FLAG_ADDR: begin
          clear_mask = pwdata[7:0] & PIF_IMPL_MASK;
        end
        PIF_ENABLE_ADDR: begin
          enable_value = pwdata[7:0] & PIF_IMPL_MASK;
        end
        default: begin
          clear_mask = 8'h00;
        end
      endcase
    end
    flag_cleared = state_reg.flag_reg & ~clear_mask;
    // a new event in the same cycle wins over the clear
    flag_set               = 8'h00;
    flag_set[PIF_OSC_BIT]  = flag_cleared[PIF_OSC_BIT] | events[PIF_OSC_BIT];
    flag_set[PIF_CMP2_BIT] = flag_cleared[PIF_CMP2_BIT] | events[PIF_CMP2_BIT];
    flag_set[PIF_CMP1_BIT] = flag_cleared[PIF_CMP1_BIT] | events[PIF_CMP1_BIT];
    flag_set[PIF_DISP_BIT] = flag_cleared[PIF_DISP_BIT] | events[PIF_DISP_BIT];
    flag_set[PIF_LVD_BIT]  = flag_cleared[PIF_LVD_BIT] | events[PIF_LVD_BIT];
    flag_set[PIF_CCP2_BIT] = flag_cleared[PIF_CCP2_BIT] | events[PIF_CCP2_BIT];
  end

  // ----------------------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------------------
  always_comb begin
    read_byte = 8'h00;
    case (paddr)
      PIF_FLAG_ADDR: begin
        read_byte = state_reg.flag_reg & PIF_IMPL_MASK;
      end
      PIF_ENABLE_ADDR: begin
        read_byte = state_reg.enable_reg;
      end
      default: begin
        read_byte = 8'h00;
      end
    endcase
    read_word = {24'h000000, read_byte};
  end

  // ----------------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------------
  always_comb begin
    state_next            = state_reg;
    state_next.sync1_reg  = raw_in;
    state_next.sync2_reg  = state_reg.sync1_reg;
    state_next.sync3_reg  = state_reg.sync2_reg;
    state_next.prev_reg   = level_now;
    state_next.flag_reg   = flag_set;
    state_next.enable_reg = enable_value;
    // read data taken in setup, stands through access
    if (rd_en) begin
      state_next.prdata_reg = read_word;
    end
  end

  // ----------------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg.flag_reg   <= PIF_FLAG_RESET;
      state_reg.enable_reg <= PIF_ENABLE_RESET;
      state_reg.sync1_reg  <= '0;
      state_reg.sync2_reg  <= '0;
      state_reg.sync3_reg  <= '0;
      state_reg.prev_reg   <= '0;
      state_reg.prdata_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------------------
  // interrupt
  // ----------------------------------------------------------------------------
  assign pending = state_reg.flag_reg & state_reg.enable_reg;
  assign irq     = |pending;

  // ----------------------------------------------------------------------------
  // bus response
  // ----------------------------------------------------------------------------
  assign pready  = 1'b1;
  assign pslverr = access_phase && !hit_any;

  // ----------------------------------------------------------------------------
  // register outputs
  // ----------------------------------------------------------------------------
  assign prdata   = state_reg.prdata_reg;
  assign flag_out = state_reg.flag_reg;
endmodule // pif_flags
`default_nettype wire

// *** sim/pif_flags_chk.sv ***
// port checker for pif_flags
`timescale 1ns/1ps
`default_nettype none
module pif_flags_chk import pif_pkg::*; (input wire logic pclk, presetn, psel, penable, pwrite,
  input wire logic irq, osc_fail_event, cmp2_output, cmp1_output, pready,
  input wire logic [11:0] paddr,
  input wire logic [7:0] flag_out);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic wr = psel && penable && pwrite && paddr == PIF_FLAG_ADDR;
  a_unimpl_zero: assert property (!flag_out[3] && !flag_out[1]) else $error("spare bit");
  a_osc_sets: assert property ($rose(osc_fail_event) |-> ##[1:6] flag_out[7])
    else $error("osc flag");
  a_cmp2_sets: assert property ($changed(cmp2_output) |-> ##[1:6] flag_out[6])
    else $error("cmp2 flag");
  a_cmp1_sets: assert property ($changed(cmp1_output) |-> ##[1:6] flag_out[5])
    else $error("cmp1 flag");
  a_irq_flag: assert property (irq |-> flag_out != 8'h00)
    else $error("irq without flag");
  a_ready_high: assert property (pready) else $error("ready low");
  a_flag_sticky: assert property (
    |($past(flag_out) & ~flag_out) |-> $past(wr) || $past(wr, 2)) else $error("flag lost");
  cover property (irq);
  cover property (wr && flag_out != 8'h00);
  cover property ($changed(cmp2_output));
endmodule // pif_flags_chk
bind pif_flags pif_flags_chk u_pif_flags_chk (.*);
`default_nettype wire

// *** sim/pif_src.sv ***
// event source model for pif_flags
`timescale 1ns/1ps
`default_nettype none
module pif_src (input wire logic pclk, input wire logic [7:0] kick, output logic osc_fail_event,
  output logic cmp2_output, cmp1_output, display_module_event, low_voltage_event, capcomp2_event);
  logic [7:0] k = 8'h00, c = 8'h00;
  always @(posedge pclk) {k, c} <= {kick, c ^ (kick & ~k & 8'h60)};
  assign {osc_fail_event, cmp2_output, cmp1_output, display_module_event} = {k[7], c[6:5], k[4]};
  assign {low_voltage_event, capcomp2_event} = {k[2], k[0]};
endmodule // pif_src
`default_nettype wire

// *** sim/tb_top.sv ***
// bench for pif_flags
`timescale 1ns/1ps
`default_nettype none
module tb_top import pif_pkg::*;;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, capcomp2_event;
  logic irq, osc_fail_event, cmp2_output, cmp1_output, display_module_event, low_voltage_event;
  logic [11:0] paddr = 0; logic [31:0] pwdata = 0, prdata; logic [7:0] kick = 0, flag_out;
  int errors = 0, cmp_count = 0; initial forever #10 pclk = ~pclk;
  pif_flags u_pif_flags (.*, .pstrb(4'hF));
  pif_src u_pif_src (.*);
  task automatic chk(input logic [31:0] g, e);
    cmp_count++; errors += int'(g !== e);
    if (g !== e) $display("[FAIL] %0t got %h exp %h", $time, g, e);
  endtask
  task automatic xfer(input logic w, logic [11:0] a, logic [31:0] d, e);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk) penable <= 1; do @(posedge pclk); while (pready !== 1'b1);
    chk(pslverr, a != PIF_FLAG_ADDR && a != PIF_ENABLE_ADDR);
    if (!w) chk(prdata, e);
    {psel, penable} <= 2'b00;
    @(posedge pclk);
  endtask
  task automatic results(input int late);
    errors += late; $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial #100000 results(1);
  initial begin
    repeat (8) @(posedge pclk); presetn <= 1; @(posedge pclk);
    xfer(0, 12'h100, 0, 0); xfer(0, PIF_FLAG_ADDR, 0, 0);
    xfer(1, PIF_ENABLE_ADDR, 32'h40, 0);
    xfer(0, PIF_ENABLE_ADDR, 0, 32'h40);
    for (int i = 0; i < 8; i++) begin
      kick <= 8'h01 << i; repeat (3) @(posedge pclk); kick <= 0; repeat (6) @(posedge pclk);
      xfer(0, PIF_FLAG_ADDR, 0, PIF_IMPL_MASK & (8'h01 << i));
      chk(irq, i == 6);
      chk(flag_out, PIF_IMPL_MASK & (8'h01 << i));
      xfer(1, PIF_FLAG_ADDR, 32'hFF, 0);
      xfer(0, PIF_FLAG_ADDR, 0, 0);
      chk(flag_out, 0);
    end
    results(0);
  end
endmodule // tb_top
`default_nettype wire
